// File: core/dcl_core.sv
// Implementation choices: the APB interface to the registers and the register addresses.
module dcl_core
  import dcl_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          nrst_i,
  // apb
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  // loop inputs
  input  wire logic          tick_i,
  input  wire logic          drive_idle_i,
  input  wire logic signed [W-1:0] active_pct_i,
  input  wire logic signed [W-1:0] ramp_freq_i,
  input  wire logic [W-1:0]  max_freq_i,
  input  wire logic [W-1:0]  rated_freq_i,
  input  wire logic [W-1:0]  volt_lim_freq_i,
  input  wire logic [W-1:0]  max_limit_i,
  // loop outputs
  output logic signed [W-1:0] out_freq_o,
  output logic               limit_active_o,
  output logic               slip_comp_en_o
);
  import dcl_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [W-1:0]        limit_reg;
  logic signed [W-1:0] torque_reg;
  logic [W-1:0]        kp_reg;
  logic [W-1:0]        ki_reg;
  logic                mode_req_reg;
  logic                mode_reg;
  logic signed [W-1:0] demand_reg;
  logic signed [W-1:0] freq_reg;
  logic signed [31:0]  integ_reg;
  logic                limit_reg_act;
  logic                slip_req_reg;

  logic                wr_en;
  logic                rd_en;
  logic [W-1:0]        eff_max;
  logic [W-1:0]        eff_limit;
  logic signed [W-1:0] wdata_s;
  logic [W-1:0]        wdata_u;

  assign wr_en    = psel_i & penable_i & pwrite_i;
  assign rd_en    = psel_i & penable_i & ~pwrite_i;
  assign pready_o = 1'b1;
  assign wdata_s  = pwdata_i[W-1:0];
  assign wdata_u  = pwdata_i[W-1:0];

  // maximum limit supplied as 100*Idrv*sqrt(1.25+pf^2)/(Imot*pf), capped
  assign eff_max   = (max_limit_i > DCL_ABS_CEIL) ? DCL_ABS_CEIL : max_limit_i;
  assign eff_limit = (limit_reg > eff_max) ? eff_max : limit_reg;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      limit_reg <= DCL_RST_LIMIT;
    end else if (wr_en && paddr_i == DCL_OFS_LIMIT) begin
      limit_reg <= (wdata_u > eff_max) ? eff_max : wdata_u;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      torque_reg <= DCL_RST_TORQUE;
    end else if (wr_en && paddr_i == DCL_OFS_TORQUE) begin
      if (wdata_s > $signed({1'b0, eff_max[W-2:0]})) begin
        torque_reg <= $signed({1'b0, eff_max[W-2:0]});
      end else if (wdata_s < -$signed({1'b0, eff_max[W-2:0]})) begin
        torque_reg <= -$signed({1'b0, eff_max[W-2:0]});
      end else begin
        torque_reg <= wdata_s;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      kp_reg <= DCL_RST_KP;
      ki_reg <= DCL_RST_KI;
    end else if (wr_en) begin
      if (paddr_i == DCL_OFS_KP) begin
        kp_reg <= (wdata_u > DCL_GAIN_MAX) ? DCL_GAIN_MAX : wdata_u;
      end
      if (paddr_i == DCL_OFS_KI) begin
        ki_reg <= (wdata_u > DCL_GAIN_MAX) ? DCL_GAIN_MAX : wdata_u;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_req_reg <= 1'b0;
      slip_req_reg <= 1'b1;
    end else if (wr_en && paddr_i == DCL_OFS_CTRL) begin
      mode_req_reg <= pwdata_i[DCL_CTRL_MODE_BIT];
      slip_req_reg <= pwdata_i[DCL_STAT_SLIP_BIT];
    end
  end

  // requested mode is adopted only while the drive is idle
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg <= 1'b0;
    end else if (drive_idle_i) begin
      mode_reg <= mode_req_reg;
    end
  end

  assign slip_comp_en_o = slip_req_reg & ~mode_reg;

  // ---------------------------------------------------------------
  // current demand
  // ---------------------------------------------------------------
  logic signed [W-1:0] demand_raw;
  logic signed [31:0]  fw_prod;
  logic [W-1:0]        abs_freq;

  assign abs_freq = freq_reg[W-1] ? W'(-freq_reg) : W'(freq_reg);
  assign fw_prod  = (rated_freq_i == '0) ? 32'(torque_reg)
                  : (32'(torque_reg) * $signed({16'h0000, abs_freq}))
                    / $signed({16'h0000, rated_freq_i});

  always_comb begin
    if (abs_freq <= volt_lim_freq_i) begin
      demand_raw = torque_reg;
    end else begin
      demand_raw = W'(fw_prod);
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      demand_reg <= '0;
    end else if (tick_i) begin
      if (demand_raw > $signed({1'b0, eff_limit[W-2:0]})) begin
        demand_reg <= $signed({1'b0, eff_limit[W-2:0]});
      end else if (demand_raw < -$signed({1'b0, eff_limit[W-2:0]})) begin
        demand_reg <= -$signed({1'b0, eff_limit[W-2:0]});
      end else begin
        demand_reg <= demand_raw;
      end
    end
  end

  // ---------------------------------------------------------------
  // pi controller
  // ---------------------------------------------------------------
  logic signed [31:0] err;
  logic signed [31:0] lim_s;
  logic signed [31:0] fmax_w;
  logic signed [31:0] integ_next;
  logic signed [31:0] pterm;
  logic signed [31:0] pi_out;
  logic signed [31:0] freq_next;
  logic               over;

  assign lim_s  = $signed({16'h0000, eff_limit});
  assign fmax_w = $signed({16'h0000, max_freq_i}) * DCL_WIDEN_NUM / DCL_WIDEN_DEN;

  always_comb begin
    err  = '0;
    over = 1'b0;
    if (mode_reg) begin
      err = 32'(demand_reg) - 32'(active_pct_i);
    end else if (32'(active_pct_i) > lim_s) begin
      err  = lim_s - 32'(active_pct_i);
      over = 1'b1;
    end else if (32'(active_pct_i) < -lim_s) begin
      err  = -lim_s - 32'(active_pct_i);
      over = 1'b1;
    end
  end

  always_comb begin
    integ_next = integ_reg + ((err * $signed({16'h0000, ki_reg})) >>> DCL_GAIN_SHIFT);
    if (!mode_reg && !over) begin
      integ_next = '0;
    end
    if (integ_next > fmax_w) begin
      integ_next = fmax_w;
    end else if (integ_next < -fmax_w) begin
      integ_next = -fmax_w;
    end
    pterm  = (err * $signed({16'h0000, kp_reg})) >>> DCL_GAIN_SHIFT;
    pi_out = integ_next + pterm;
    if (mode_reg) begin
      freq_next = pi_out;
    end else begin
      freq_next = 32'(ramp_freq_i) + pi_out;
    end
    if (freq_next > fmax_w) begin
      freq_next = fmax_w;
    end else if (freq_next < -fmax_w) begin
      freq_next = -fmax_w;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      integ_reg     <= '0;
      freq_reg      <= '0;
      limit_reg_act <= 1'b0;
    end else if (tick_i) begin
      integ_reg     <= integ_next;
      freq_reg      <= W'(freq_next);
      limit_reg_act <= over;
    end
  end

  assign out_freq_o     = freq_reg;
  assign limit_active_o = limit_reg_act;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    prdata_o  = 32'h0000_0000;
    pslverr_o = 1'b0;
    if (rd_en) begin
      unique case (paddr_i)
        DCL_OFS_DEMAND: prdata_o = {{16{demand_reg[W-1]}}, demand_reg};
        DCL_OFS_LIMIT:  prdata_o = {16'h0000, limit_reg};
        DCL_OFS_TORQUE: prdata_o = {{16{torque_reg[W-1]}}, torque_reg};
        DCL_OFS_KP:     prdata_o = {16'h0000, kp_reg};
        DCL_OFS_KI:     prdata_o = {16'h0000, ki_reg};
        DCL_OFS_CTRL:   prdata_o = {30'h0, slip_req_reg, mode_req_reg};
        DCL_OFS_STAT:   prdata_o = {29'h0, mode_reg, slip_comp_en_o, limit_reg_act};
        DCL_OFS_MAXLIM: prdata_o = {16'h0000, eff_max};
        default:        pslverr_o = 1'b1;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_lim_reset;
    @(posedge core_clk_i) $rose(nrst_i) |-> limit_reg == DCL_RST_LIMIT;
  endproperty
  a_lim_reset: assert property (p_lim_reset) else $error("limit reset value wrong");

  property p_lim_ceil;
    @(posedge core_clk_i) disable iff (!nrst_i) eff_limit <= DCL_ABS_CEIL;
  endproperty
  a_lim_ceil: assert property (p_lim_ceil) else $error("limit above ceiling");

  property p_kp_max;
    @(posedge core_clk_i) disable iff (!nrst_i) kp_reg <= DCL_GAIN_MAX && ki_reg <= DCL_GAIN_MAX;
  endproperty
  a_kp_max: assert property (p_kp_max) else $error("gain above range");

  property p_mode_idle;
    @(posedge core_clk_i) disable iff (!nrst_i) !drive_idle_i |=> $stable(mode_reg);
  endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("mode changed while running");

  property p_slip_off;
    @(posedge core_clk_i) disable iff (!nrst_i) mode_reg |-> !slip_comp_en_o;
  endproperty
  a_slip_off: assert property (p_slip_off) else $error("slip comp on in torque mode");

  property p_freq_clamp;
    @(posedge core_clk_i) disable iff (!nrst_i)
      tick_i |=> (32'(freq_reg) <= $past(fmax_w)) && (32'(freq_reg) >= -$past(fmax_w));
  endproperty
  a_freq_clamp: assert property (p_freq_clamp) else $error("frequency outside clamp");

  property p_demand_lim;
    @(posedge core_clk_i) disable iff (!nrst_i)
      tick_i |=> 32'(demand_reg) <= $past(lim_s) && 32'(demand_reg) >= -$past(lim_s);
  endproperty
  a_demand_lim: assert property (p_demand_lim) else $error("demand above limit");

  property p_no_trim;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (tick_i && !mode_reg && !over && 32'(ramp_freq_i) <= fmax_w && 32'(ramp_freq_i) >= -fmax_w)
      |=> freq_reg == $past(ramp_freq_i);
  endproperty
  a_no_trim: assert property (p_no_trim) else $error("frequency trimmed within limit");

  property p_motor_down;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (tick_i && !mode_reg && 32'(active_pct_i) > lim_s) |-> err < 0;
  endproperty
  a_motor_down: assert property (p_motor_down) else $error("motoring correction wrong sign");

  property p_regen_up;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (tick_i && !mode_reg && 32'(active_pct_i) < -lim_s) |-> err > 0;
  endproperty
  a_regen_up: assert property (p_regen_up) else $error("regen correction wrong sign");

  property p_integ_sat;
    @(posedge core_clk_i) disable iff (!nrst_i)
      tick_i |=> (integ_reg <= $past(fmax_w)) && (integ_reg >= -$past(fmax_w));
  endproperty
  a_integ_sat: assert property (p_integ_sat) else $error("integrator outside clamp");

  c_limit: cover property (@(posedge core_clk_i) disable iff (!nrst_i) tick_i && over);
  c_torque: cover property (@(posedge core_clk_i) disable iff (!nrst_i) tick_i && mode_reg);
  c_fw: cover property (@(posedge core_clk_i) disable iff (!nrst_i) abs_freq > volt_lim_freq_i);
  c_regen: cover property (@(posedge core_clk_i) disable iff (!nrst_i) tick_i && over && err > 0);
endmodule

// File: core/dcl_pkg.sv
package dcl_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] DCL_OFS_DEMAND = 8'h00;
  localparam logic [7:0] DCL_OFS_LIMIT  = 8'h04;
  localparam logic [7:0] DCL_OFS_TORQUE = 8'h08;
  localparam logic [7:0] DCL_OFS_KP     = 8'h0C;
  localparam logic [7:0] DCL_OFS_KI     = 8'h10;
  localparam logic [7:0] DCL_OFS_CTRL   = 8'h14;
  localparam logic [7:0] DCL_OFS_STAT   = 8'h18;
  localparam logic [7:0] DCL_OFS_MAXLIM = 8'h1C;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int DCL_CTRL_MODE_BIT  = 0;
  localparam int DCL_STAT_LIMIT_BIT = 0;
  localparam int DCL_STAT_SLIP_BIT  = 1;
  localparam int DCL_STAT_MODE_BIT  = 2;
  localparam logic [15:0] DCL_RST_LIMIT  = 16'h00A5;
  localparam logic [15:0] DCL_RST_TORQUE = 16'h0000;
  localparam logic [15:0] DCL_RST_KP     = 16'h0014;
  localparam logic [15:0] DCL_RST_KI     = 16'h0028;
  localparam logic [15:0] DCL_GAIN_MAX   = 16'h00FA;
  localparam logic [15:0] DCL_ABS_CEIL   = 16'h03E8;
  localparam logic [15:0] DCL_PCT_100    = 16'h0064;
  // widen maximum frequency by 20 percent: f*6/5
  localparam int DCL_WIDEN_NUM = 6;
  localparam int DCL_WIDEN_DEN = 5;
  // gain scaling shift for PI terms
  localparam int DCL_GAIN_SHIFT = 8;
endpackage

// File: dv/dcl_motor_model.sv
module dcl_motor_model (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  // loop side
  input  wire logic               tick_i,
  input  wire logic               slow_i,
  input  wire logic signed [15:0] load_i,
  output logic signed [15:0]      cur_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // active current follows the load at once, or a quarter step per tick
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_o <= 16'sh0000;
    end else if (tick_i) begin
      cur_o <= slow_i ? cur_o + (load_i - cur_o) / 4 : load_i;
    end
  end
endmodule

// File: dv/test_drive_current_limit_torque_loop.sv
module test_drive_current_limit_torque_loop;
  import dcl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // -------
  // signals
  // -------
  logic               clk, nrst, psel, penable, pwrite, tick, tick_en;
  logic               idle, slow, pready, pslverr, lim_act, slip, e;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, q;
  logic signed [15:0] act, ramp, load, ofreq;
  logic [15:0]        fmax, frat, fvl, maxl;
  logic signed [15:0] s_freq;
  logic               s_lim, s_slip;
  int                 failures, samples_checked, v, lmax, tq;

  dcl_core DUT (.core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .tick_i(tick), .drive_idle_i(idle),
    .active_pct_i(act), .ramp_freq_i(ramp), .max_freq_i(fmax), .rated_freq_i(frat),
    .volt_lim_freq_i(fvl), .max_limit_i(maxl), .out_freq_o(ofreq),
    .limit_active_o(lim_act), .slip_comp_en_o(slip));
  dcl_motor_model motor (.clk_i(clk), .nrst_i(nrst), .tick_i(tick), .slow_i(slow),
    .load_i(load), .cur_o(act));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) tick <= tick_en & ~tick;
  // snapshot of settled outputs, taken away from the launching edge
  always @(negedge clk) begin
    s_freq = ofreq;
    s_lim  = lim_act;
    s_slip = slip;
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  // -------
  // tasks
  // -------
  function automatic int clip(input int x, input int lo, input int hi);
    return (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
    samples_checked++;
    if (x !== y) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", n, x, y);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      rdy = pready;
      q = prdata;
      e = pslverr;
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask
  task automatic wt(input int k);
    repeat (2 * k) @(posedge clk);
  endtask
  // -------
  // stimulus
  // -------
  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; tick = 1'b0; tick_en = 1'b0; idle = 1'b0; slow = 1'b0;
    load = 16'sh0000; ramp = 16'sh0000; fmax = 16'h03E8; frat = 16'h003C;
    fvl = 16'h03E8; maxl = 16'h01F4; failures = 0; samples_checked = 0;
    v = $urandom(25);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd("limit", DCL_OFS_LIMIT, 32'h000000A5);
    rd("torque", DCL_OFS_TORQUE, 32'h0);
    rd("kp", DCL_OFS_KP, 32'h14);
    rd("ki", DCL_OFS_KI, 32'h28);
    chk("slip", 32'h1, s_slip);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, e);
    chk("unmapped_data", 32'h0, q);
    apb(1'b1, DCL_OFS_DEMAND, 32'h7B);
    rd("demand_ro", DCL_OFS_DEMAND, 32'h0);
    for (int i = 0; i < 6; i++) begin
      maxl <= 16'($urandom_range(1100, 100));
      v = $urandom_range(511, 0);
      apb(1'b1, DCL_OFS_KP, v);
      rd("kp", DCL_OFS_KP, clip(v, 0, 250));
      v = $urandom_range(511, 0);
      apb(1'b1, DCL_OFS_KI, v);
      rd("ki", DCL_OFS_KI, clip(v, 0, 250));
      lmax = clip(maxl, 0, 1000);
      v = $urandom_range(1200, 0);
      apb(1'b1, DCL_OFS_LIMIT, v);
      rd("limit", DCL_OFS_LIMIT, clip(v, 0, lmax));
      tq = $urandom_range(2400, 0) - 1200;
      apb(1'b1, DCL_OFS_TORQUE, tq);
      rd("torque", DCL_OFS_TORQUE, clip(tq, -lmax, lmax));
    end
    maxl <= 16'h01F4;
    apb(1'b1, DCL_OFS_KP, 32'h14);
    apb(1'b1, DCL_OFS_KI, 32'h28);
    apb(1'b1, DCL_OFS_LIMIT, 32'h64);
    load <= 16'sd50;
    ramp <= 16'sd300;
    slow <= 1'b1;
    tick_en <= 1'b1;
    wt(20);
    chk("freq_pass", ramp, s_freq);
    chk("no_limit", 32'h0, s_lim);
    load <= 16'sd150;
    wt(20);
    chk("limit_on", 32'h1, s_lim);
    chk("motoring_down", 32'h1, s_freq < ramp);
    load <= -16'sd150;
    wt(40);
    chk("regen_up", 32'h1, s_freq > ramp);
    v = s_freq;
    ramp <= 16'sd400;
    wt(3);
    chk("ramp_runs", 32'h1, s_freq >= v + 100);
    load <= 16'sd0;
    ramp <= 16'sd0;
    fmax <= 16'h0064;
    apb(1'b1, DCL_OFS_LIMIT, 32'hA5);
    apb(1'b1, DCL_OFS_CTRL, 32'h3);
    wt(3);
    chk("slip_busy", 32'h1, s_slip);
    rd("mode_busy", DCL_OFS_STAT, 32'h2);
    idle <= 1'b1;
    wt(2);
    idle <= 1'b0;
    chk("slip_off", 32'h0, s_slip);
    apb(1'b0, DCL_OFS_STAT, 32'h0);
    chk("mode_idle", 32'h1, q[DCL_STAT_MODE_BIT]);
    apb(1'b1, DCL_OFS_TORQUE, 32'd50);
    wt(150);
    chk("torque_clamp_hi", 32'd120, s_freq);
    rd("demand", DCL_OFS_DEMAND, 32'd50);
    fvl <= 16'h0032;
    wt(3);
    rd("demand_fw", DCL_OFS_DEMAND, 32'd100);
    fvl <= 16'h03E8;
    apb(1'b1, DCL_OFS_TORQUE, 32'd300);
    wt(3);
    rd("demand_clamp", DCL_OFS_DEMAND, 32'd165);
    apb(1'b1, DCL_OFS_TORQUE, -32'sd20);
    wt(200);
    chk("torque_clamp_lo", -32'sd120, s_freq);
    rd("demand_neg", DCL_OFS_DEMAND, -32'sd20);
    tally_and_finish();
  end
endmodule
